/* verilog/scc_top.sv */
// sleep and clock source control with axi4-lite register slave
// Contract
// - after reset system clock runs from 2mhz oscillator, other sources, calibrators, pll off
// - tiny-power 32khz oscillator on only while something uses it; gives 1khz tick
// - tiny-power oscillator selectable as timekeeping and display clock source
// - 32.768khz oscillator calibration writable; 32.768khz and 1.024khz outputs provided
// - enableable frequency-lock calibrators trim the 2mhz and 32mhz oscillators
// - pll multiplication factor software-selected from 1 to 31
// - external clock accepted on main crystal input or any port c pin
// - five sleep modes, each entered from active by the sleep instruction
// - on wake, higher-priority pending interrupts first, then wake handler, then next instruction
// - cpu held halted four cycles after every wake-up
// - state kept during sleep; reset in sleep restarts at reset vector
// - enabled interrupts and reset sources wake the device, per mode wake sources
// - per-peripheral clock gating freezes peripheral, usable in active and idle
// - idle stops cpu and nvm after programming ends; peripherals keep running
// - power-down stops every clock but an enabled 32.768khz oscillator, timekeeping counter clock included; selected tiny-power oscillator keeps running
// - power-down wakes only on twi address match, async port, usb resume
// - power-save like power-down but enabled timekeeping counter runs and wakes
// - power-save keeps enabled display running, frame-complete interrupt wakes
// - standby like power-down but enabled clock sources keep running
// - extended standby like power-save with enabled clock sources kept running
// - every reset disables all clock sources except the 2mhz and tiny-power oscillators
// - system clock source and prescalers changeable by software at any time
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.svh"
module scc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_instr,
  input wire logic nvm_busy,
  input wire logic irq_any,
  input wire logic irq_higher_pending,
  input wire logic irq_twi_addr_match,
  input wire logic irq_port_async,
  input wire logic irq_usb_resume,
  input wire logic irq_rtc,
  input wire logic irq_lcd_frame,
  input wire logic rtc_enabled,
  input wire logic lcd_enabled,
  input wire logic tiny_power_osc_tick,
  input wire logic osc32k_tick,
  input wire logic osc_locked,
  output logic cpu_run,
  output logic cpu_halted,
  output logic nvm_clk_en,
  output logic service_higher_first,
  output logic resume_next_instr,
  output logic [7:0] periph_clk_en,
  output logic int_ctrl_clk_en,
  output logic rtc_clk_en,
  output logic lcd_clk_en,
  output logic [7:0] osc_en,
  output logic tiny_power_osc_en,
  output logic tiny_power_1khz,
  output logic osc32k_1024hz,
  output logic osc32k_32768hz,
  output logic [2:0] sys_clk_sel,
  output logic [3:0] sys_presc,
  output logic [4:0] pll_mul,
  output logic [7:0] osc32k_cal,
  output logic [1:0] rtc_src_sel,
  output logic [1:0] lcd_src_sel,
  output logic ext_clk_on_port_c,
  output logic [2:0] ext_clk_pin
);
  import scc_pkg::*;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic known_off(input logic [7:0] a);
    return (a == `SCC_OFF_CLKEN) || (a == `SCC_OFF_SYSSEL) || (a == `SCC_OFF_PLL) || (a == `SCC_OFF_CAL32K) ||
           (a == `SCC_OFF_SLEEP) || (a == `SCC_OFF_PWRRED) || (a == `SCC_OFF_STATUS) ||
           (a == `SCC_OFF_WAKEEN) || (a == `SCC_OFF_EXTSEL);
  endfunction

  // axi write channel: address and data latched in either order
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr[7:0];
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= known_off(aw_addr) ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic wr_hit(input logic [7:0] off, input logic fire, input logic [7:0] a);
    return fire && (a == off);
  endfunction

  // control registers; reset brings every source but the 2mhz and tiny-power ones down
  logic [7:0] clk_en_reg;
  logic [31:0] wv;
  assign wv = wmerge(32'h0000_0000, w_data, w_strb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_en_reg <= `SCC_CLKEN_RST;
    end else if (wr_hit(`SCC_OFF_CLKEN, wr_fire, aw_addr) && w_strb[0]) begin
      clk_en_reg <= wv[7:0];
    end
  end

  // source select and prescaler may change at any time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_clk_sel <= `SCC_SYSSEL_RST;
      sys_presc <= `SCC_PRESC_RST;
    end else if (wr_hit(`SCC_OFF_SYSSEL, wr_fire, aw_addr) && w_strb[0]) begin
      sys_clk_sel <= w_data[2:0];
      sys_presc <= w_data[7:4];
    end
  end

  // factor of zero is refused and keeps the old value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_mul <= `SCC_PLL_MUL_RST;
    end else if (wr_hit(`SCC_OFF_PLL, wr_fire, aw_addr) && w_strb[0] && (w_data[4:0] >= `SCC_PLL_MUL_MIN)) begin
      pll_mul <= w_data[4:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc32k_cal <= `SCC_CAL32K_RST;
    end else if (wr_hit(`SCC_OFF_CAL32K, wr_fire, aw_addr) && w_strb[0]) begin
      osc32k_cal <= w_data[7:0];
    end
  end

  logic sleep_en;
  scc_sleep_mode_e sleep_mode;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_en <= 1'b0;
      sleep_mode <= scc_sm_idle;
    end else if (wr_hit(`SCC_OFF_SLEEP, wr_fire, aw_addr) && w_strb[0]) begin
      sleep_en <= w_data[`SCC_SLEEP_EN];
      sleep_mode <= scc_sleep_mode_e'(w_data[`SCC_SLEEP_MODE_LSB +: 3]);
    end
  end

  logic [7:0] pwr_red;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_red <= 8'h00;
    end else if (wr_hit(`SCC_OFF_PWRRED, wr_fire, aw_addr) && w_strb[0]) begin
      pwr_red <= w_data[7:0];
    end
  end

  logic wake_en;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_en <= 1'b1;
    end else if (wr_hit(`SCC_OFF_WAKEEN, wr_fire, aw_addr) && w_strb[0]) begin
      wake_en <= w_data[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rtc_src_sel <= 2'h0;
      lcd_src_sel <= 2'h0;
      ext_clk_on_port_c <= 1'b0;
      ext_clk_pin <= 3'h0;
    end else if (wr_hit(`SCC_OFF_EXTSEL, wr_fire, aw_addr) && w_strb[0]) begin
      rtc_src_sel <= w_data[1:0];
      lcd_src_sel <= w_data[3:2];
      ext_clk_on_port_c <= w_data[4];
      ext_clk_pin <= w_data[7:5];
    end
  end

  // sleep sequencer
  scc_state_e state, next_state;
  logic [2:0] halt_cnt;
  logic wake_req;

  always_comb begin
    wake_req = 1'b0;
    unique case (sleep_mode)
      scc_sm_idle: wake_req = irq_any;
      scc_sm_pdown, scc_sm_standby: wake_req = irq_twi_addr_match || irq_port_async || irq_usb_resume;
      scc_sm_psave, scc_sm_estandby: wake_req = irq_twi_addr_match || irq_port_async || irq_usb_resume ||
                                    (rtc_enabled && irq_rtc) || (lcd_enabled && irq_lcd_frame);
      default: wake_req = irq_any;
    endcase
    wake_req = wake_req && wake_en;
  end

  always_comb begin
    next_state = state;
    unique case (state)
      scc_st_active: if (sleep_instr && sleep_en) next_state = scc_st_sleep;
      scc_st_sleep: if (wake_req) next_state = scc_st_halt;
      scc_st_halt: if (halt_cnt == 3'(`SCC_WAKE_HALT_CYC - 1)) next_state = scc_st_resume;
      scc_st_resume: next_state = scc_st_active;
    endcase
  end

  // reset during sleep lands in active, i.e. restart at the reset vector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= scc_st_active;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halt_cnt <= 3'h0;
    end else if (state == scc_st_halt) begin
      halt_cnt <= halt_cnt + 3'h1;
    end else begin
      halt_cnt <= 3'h0;
    end
  end

  // clock gating outputs registered so glitch-free changes
  logic asleep;
  assign asleep = (state == scc_st_sleep);
  logic mode_keeps_src, mode_keeps_rtc;
  assign mode_keeps_src = (sleep_mode == scc_sm_idle) || (sleep_mode == scc_sm_standby) || (sleep_mode == scc_sm_estandby);
  assign mode_keeps_rtc = (sleep_mode == scc_sm_idle) || (sleep_mode == scc_sm_psave) || (sleep_mode == scc_sm_estandby);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_run <= 1'b1;
      cpu_halted <= 1'b0;
      nvm_clk_en <= 1'b1;
      service_higher_first <= 1'b0;
      resume_next_instr <= 1'b0;
    end else begin
      cpu_run <= (next_state == scc_st_active) || (next_state == scc_st_resume);
      cpu_halted <= (next_state == scc_st_sleep) || (next_state == scc_st_halt);
      // nvm stops only once ongoing programming is done
      nvm_clk_en <= !(next_state == scc_st_sleep) || nvm_busy;
      service_higher_first <= (next_state == scc_st_resume) && irq_higher_pending;
      resume_next_instr <= (next_state == scc_st_resume);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_clk_en <= 8'hff;
      int_ctrl_clk_en <= 1'b1;
      rtc_clk_en <= 1'b0;
      lcd_clk_en <= 1'b0;
      osc_en <= `SCC_CLKEN_RST;
    end else begin
      periph_clk_en <= (asleep && sleep_mode != scc_sm_idle) ? 8'h00 : ~pwr_red;
      int_ctrl_clk_en <= !asleep || (sleep_mode == scc_sm_idle);
      rtc_clk_en <= rtc_enabled && (!asleep || mode_keeps_rtc);
      lcd_clk_en <= lcd_enabled && (!asleep || mode_keeps_rtc);
      osc_en <= (asleep && !mode_keeps_src) ? (clk_en_reg & 8'(1 << `SCC_CLKEN_OSC32K)) : clk_en_reg;
    end
  end

  // tiny-power osc demanded by any user that selects it (select code 1)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tiny_power_osc_en <= 1'b1;
    end else begin
      tiny_power_osc_en <= (rtc_enabled && rtc_src_sel == 2'h1) || (lcd_enabled && lcd_src_sel == 2'h1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tiny_power_1khz <= 1'b0;
      osc32k_1024hz <= 1'b0;
      osc32k_32768hz <= 1'b0;
    end else begin
      tiny_power_1khz <= tiny_power_osc_en && tiny_power_osc_tick;
      osc32k_1024hz <= osc_en[`SCC_CLKEN_OSC32K] && osc32k_tick;
      osc32k_32768hz <= osc_en[`SCC_CLKEN_OSC32K];
    end
  end

  // read channel, one cycle latency
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (s_axi_araddr[7:0])
      `SCC_OFF_CLKEN: rd_mux = {24'h0, clk_en_reg};
      `SCC_OFF_SYSSEL: rd_mux = {24'h0, sys_presc, 1'b0, sys_clk_sel};
      `SCC_OFF_PLL: rd_mux = {27'h0, pll_mul};
      `SCC_OFF_CAL32K: rd_mux = {24'h0, osc32k_cal};
      `SCC_OFF_SLEEP: rd_mux = {28'h0, sleep_mode, sleep_en};
      `SCC_OFF_PWRRED: rd_mux = {24'h0, pwr_red};
      `SCC_OFF_STATUS: rd_mux = {23'h0, osc_locked, tiny_power_osc_en, state, halt_cnt};
      `SCC_OFF_WAKEEN: rd_mux = {31'h0, wake_en};
      `SCC_OFF_EXTSEL: rd_mux = {24'h0, ext_clk_pin, ext_clk_on_port_c, lcd_src_sel, rtc_src_sel};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= known_off(s_axi_araddr[7:0]) ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* verilog/scc_map.svh */
// register offsets, field positions, reset values and timing counts of the sleep and clock control block
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH
`define SCC_OFF_CLKEN 8'h00
`define SCC_OFF_SYSSEL 8'h04
`define SCC_OFF_PLL 8'h08
`define SCC_OFF_CAL32K 8'h0c
`define SCC_OFF_SLEEP 8'h10
`define SCC_OFF_PWRRED 8'h14
`define SCC_OFF_STATUS 8'h18
`define SCC_OFF_WAKEEN 8'h1c
`define SCC_OFF_EXTSEL 8'h20
`define SCC_CLKEN_OSC32K 0
`define SCC_CLKEN_XOSC32K 1
`define SCC_CLKEN_XOSC 2
`define SCC_CLKEN_OSC2M 3
`define SCC_CLKEN_OSC32M 4
`define SCC_CLKEN_PLL 5
`define SCC_CLKEN_FLC2M 6
`define SCC_CLKEN_FLC32M 7
`define SCC_CLKEN_RST 8'h08
`define SCC_SYSSEL_RST 3'h0
`define SCC_PLL_MUL_RST 5'h01
`define SCC_PLL_MUL_MIN 5'h01
`define SCC_PLL_MUL_MAX 5'h1f
`define SCC_CAL32K_RST 8'h80
`define SCC_SLEEP_EN 0
`define SCC_SLEEP_MODE_LSB 1
`define SCC_PRESC_RST 4'h0
`define SCC_WAKE_HALT_NS 400
`define SCC_CLK_PERIOD_NS 100
`define SCC_WAKE_HALT_CYC ((`SCC_WAKE_HALT_NS + `SCC_CLK_PERIOD_NS - 1) / `SCC_CLK_PERIOD_NS)
`endif

/* verilog/scc_pkg.sv */
// types of the sleep and clock control block
`default_nettype none
package scc_pkg;
  typedef enum logic [2:0] {
    scc_sm_idle = 3'h0,
    scc_sm_pdown = 3'h2,
    scc_sm_psave = 3'h3,
    scc_sm_standby = 3'h6,
    scc_sm_estandby = 3'h7
  } scc_sleep_mode_e;
  typedef enum logic [2:0] {
    scc_sys_osc2m = 3'h0,
    scc_sys_osc32m = 3'h1,
    scc_sys_osc32k = 3'h2,
    scc_sys_xosc = 3'h3,
    scc_sys_pll = 3'h4
  } scc_sys_src_e;
  typedef enum logic [3:0] {
    scc_st_active = 4'b0001,
    scc_st_sleep = 4'b0010,
    scc_st_halt = 4'b0100,
    scc_st_resume = 4'b1000
  } scc_state_e;
endpackage
`default_nettype wire

/* tb/scc_monitor.sv */
// assertion checker for the sleep and clock control block
`timescale 1ns/1ps
`default_nettype none
module scc_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sleep_instr,
  input wire logic cpu_halted,
  input wire logic cpu_run,
  input wire logic resume_next_instr,
  input wire logic [7:0] osc_en,
  input wire logic [2:0] sys_clk_sel,
  input wire logic [4:0] pll_mul,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic nvm_busy,
  input wire logic nvm_clk_en,
  input wire logic rtc_enabled,
  input wire logic [1:0] rtc_src_sel,
  input wire logic lcd_enabled,
  input wire logic [1:0] lcd_src_sel,
  input wire logic tiny_power_osc_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_sleep_entry;
    $rose(cpu_halted) |-> $past(sleep_instr);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("halt without sleep request");
  property p_wake_halt;
    resume_next_instr |-> $past(cpu_halted, 1) && $past(cpu_halted, 2) && $past(cpu_halted, 3) && $past(cpu_halted, 4);
  endproperty
  a_wake_halt: assert property (p_wake_halt) else $error("resume without four halted cycles");
  property p_halt_stops_cpu;
    cpu_halted |-> !cpu_run;
  endproperty
  a_halt_stops_cpu: assert property (p_halt_stops_cpu) else $error("cpu runs while halted");
  property p_reset_clocks;
    $rose(aresetn) |-> osc_en == 8'h08 && sys_clk_sel == 3'h0 && pll_mul == 5'h01 && cpu_run;
  endproperty
  a_reset_clocks: assert property (p_reset_clocks) else $error("clock state wrong after reset");
  property p_pll_range;
    pll_mul != 5'h00;
  endproperty
  a_pll_range: assert property (p_pll_range) else $error("pll factor zero");
  property p_bresp_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");
  property p_rdata_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped");
  property p_nvm_finish;
    nvm_busy |-> ##[0:1] nvm_clk_en;
  endproperty
  a_nvm_finish: assert property (p_nvm_finish) else $error("nvm clock cut during programming");
  property p_tiny_demand;
    (rtc_enabled && rtc_src_sel == 2'h1) || (lcd_enabled && lcd_src_sel == 2'h1) |-> ##[0:2] tiny_power_osc_en;
  endproperty
  a_tiny_demand: assert property (p_tiny_demand) else $error("tiny oscillator off while used");
  c_sleep: cover property ($rose(cpu_halted));
  c_resume: cover property (resume_next_instr);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind scc_top scc_monitor mon (
  .aclk, .aresetn, .sleep_instr, .cpu_halted, .cpu_run, .resume_next_instr, .osc_en, .sys_clk_sel,
  .pll_mul, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .nvm_busy, .nvm_clk_en, .rtc_enabled, .rtc_src_sel, .lcd_enabled, .lcd_src_sel, .tiny_power_osc_en
);
`default_nettype wire

/* tb/scc_cpu_model.sv */
// behavioural cpu core and interrupt controller facing the sleep controller
`timescale 1ns/1ps
`default_nettype none
module scc_cpu_model (
  input wire logic aclk,
  input wire logic resume_next_instr,
  output logic sleep_instr,
  output logic [6:0] irq
);
  initial begin
    sleep_instr = 1'b0;
    irq = 7'h00;
  end
  task automatic do_sleep();
    @(posedge aclk);
    sleep_instr <= 1'b1;
    @(posedge aclk);
    sleep_instr <= 1'b0;
  endtask
  // lag models a slow source that raises its request late
  task automatic raise(input logic [6:0] m, input int lag);
    @(posedge aclk);
    repeat (lag) @(posedge aclk);
    irq <= m;
  endtask
  // level requests stay up until the handler has run, so a late wake is not lost
  always @(posedge aclk) begin
    if (resume_next_instr) begin
      irq <= 7'h00;
    end
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the sleep and clock control block
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.svh"
module testbench;
  import scc_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sleep_instr, nvm_busy;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb, sys_presc, tk;
  logic [1:0] s_axi_bresp, s_axi_rresp, rtc_src_sel, lcd_src_sel;
  logic [6:0] irq;
  logic rtc_enabled, lcd_enabled, tiny_power_osc_tick, osc32k_tick, osc_locked, cpu_run, cpu_halted;
  logic nvm_clk_en, service_higher_first, resume_next_instr, int_ctrl_clk_en, rtc_clk_en, lcd_clk_en;
  logic tiny_power_osc_en, tiny_power_1khz, osc32k_1024hz, osc32k_32768hz, ext_clk_on_port_c;
  logic [7:0] periph_clk_en, osc_en, osc32k_cal;
  logic [2:0] sys_clk_sel, ext_clk_pin;
  logic [4:0] pll_mul;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  int n1, n2;
  scc_top DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sleep_instr, .nvm_busy, .irq_any(irq[0]), .irq_higher_pending(irq[1]), .irq_twi_addr_match(irq[2]),
    .irq_port_async(irq[3]), .irq_usb_resume(irq[4]), .irq_rtc(irq[5]), .irq_lcd_frame(irq[6]),
    .rtc_enabled, .lcd_enabled, .tiny_power_osc_tick, .osc32k_tick, .osc_locked, .cpu_run, .cpu_halted,
    .nvm_clk_en, .service_higher_first, .resume_next_instr, .periph_clk_en, .int_ctrl_clk_en, .rtc_clk_en,
    .lcd_clk_en, .osc_en, .tiny_power_osc_en, .tiny_power_1khz, .osc32k_1024hz, .osc32k_32768hz,
    .sys_clk_sel, .sys_presc, .pll_mul, .osc32k_cal, .rtc_src_sel, .lcd_src_sel, .ext_clk_on_port_c,
    .ext_clk_pin
  );
  scc_cpu_model cpu (.aclk, .resume_next_instr, .sleep_instr, .irq);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // prescaler ticks and the hang limit
  always @(posedge aclk) begin
    tk <= tk + 4'h1;
    tiny_power_osc_tick <= (tk == 4'h0);
    osc32k_tick <= (tk == 4'h8);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // readies are sampled at the falling edge, where they match the coming rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw, ta, tw;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge aclk);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        s_axi_wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    check("bresp", s_axi_bresp, er);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    @(negedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    check("rdata", s_axi_rdata, ed);
    check("rresp", s_axi_rresp, er);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    @(negedge aclk);
  endtask
  task automatic sleep_case(input logic [2:0] m, input logic [6:0] nw, input logic [6:0] wk,
    input logic [7:0] ep, input logic ec);
    int n;
    logic hi;
    wr(`SCC_OFF_SLEEP, {28'h0, m, 1'b1}, 2'h0);
    cpu.do_sleep();
    repeat (3) @(negedge aclk);
    check("halted", cpu_halted, 1'b1);
    check("periph_clk", periph_clk_en, ep);
    check("rtc_lcd_clk", {rtc_clk_en, lcd_clk_en}, {ec, ec});
    check("nvm_clk", nvm_clk_en, 1'b0);
    check("intc_clk", int_ctrl_clk_en, m == 3'h0);
    check("osc_kept", osc_en, (m[2] || m == 3'h0) ? 8'h08 : 8'h00);
    cpu.raise(nw, 0);
    repeat (12) @(negedge aclk);
    check("no_wake", cpu_halted, 1'b1);
    cpu.raise(nw | wk, 2);
    n = 0;
    hi = 1'b0;
    do begin
      @(negedge aclk);
      hi = hi | service_higher_first;
      n++;
    end while (resume_next_instr !== 1'b1 && n < 60);
    check("resume", resume_next_instr, 1'b1);
    check("higher_first", hi, wk[1]);
    repeat (2) @(negedge aclk);
    check("run", cpu_run, 1'b1);
  endtask
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, nvm_busy} = 6'h00;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'hf;
    tk = 4'h0;
    {tiny_power_osc_tick, osc32k_tick, osc_locked, rtc_enabled, lcd_enabled} = 5'h07;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check("osc_en", osc_en, 8'h08);
    check("sys_sel", sys_clk_sel, 3'h0);
    check("cal", osc32k_cal, 8'h80);
    rd(`SCC_OFF_CLKEN, 32'h08, 2'h0);
    @(posedge aclk);
    nvm_busy <= 1'b1;
    wr(`SCC_OFF_PLL, 32'h1f, 2'h0);
    wr(`SCC_OFF_PLL, 32'h00, 2'h0);
    rd(`SCC_OFF_PLL, 32'h1f, 2'h0);
    check("pll_max", pll_mul, 5'h1f);
    @(posedge aclk);
    nvm_busy <= 1'b0;
    wr(`SCC_OFF_SYSSEL, 32'h54, 2'h0);
    check("sys_sel", {sys_presc, 1'b0, sys_clk_sel}, 8'h54);
    wr(`SCC_OFF_CAL32K, 32'h3c, 2'h0);
    check("cal", osc32k_cal, 8'h3c);
    wr(`SCC_OFF_CLKEN, 32'hc8, 2'h0);
    check("osc_en", osc_en, 8'hc8);
    wr(`SCC_OFF_PWRRED, 32'h0f, 2'h0);
    check("gated", periph_clk_en, 8'hf0);
    wr(`SCC_OFF_PWRRED, 32'h00, 2'h0);
    // tiny-power oscillator demanded by both timekeeping and display selects
    wr(`SCC_OFF_EXTSEL, 32'hb5, 2'h0);
    check("ext_sel", {ext_clk_pin, ext_clk_on_port_c, lcd_src_sel, rtc_src_sel}, 8'hb5);
    check("tiny_on", tiny_power_osc_en, 1'b1);
    wr(`SCC_OFF_CLKEN, 32'h09, 2'h0);
    n1 = 0;
    n2 = 0;
    repeat (16) begin
      @(negedge aclk);
      n1 += tiny_power_1khz;
      n2 += osc32k_1024hz;
    end
    check("tick_1k", n1, 1);
    check("tick_1024", n2, 1);
    check("out_32768", osc32k_32768hz, 1'b1);
    wr(`SCC_OFF_EXTSEL, 32'h00, 2'h0);
    check("tiny_off", tiny_power_osc_en, 1'b0);
    wr(`SCC_OFF_CLKEN, 32'h08, 2'h0);
    wr(8'h40, 32'h1, 2'h2);
    rd(8'h40, 32'h0, 2'h2);
    // sleep instruction with sleep disabled must be ignored
    wr(`SCC_OFF_SLEEP, {28'h0, scc_sm_pdown, 1'b0}, 2'h0);
    cpu.do_sleep();
    repeat (3) @(negedge aclk);
    check("ignored", {cpu_run, cpu_halted}, 2'b10);
    sleep_case(scc_sm_idle, 7'h00, 7'h03, 8'hff, 1'b1);
    sleep_case(scc_sm_pdown, 7'h21, 7'h04, 8'h00, 1'b0);
    sleep_case(scc_sm_pdown, 7'h21, 7'h10, 8'h00, 1'b0);
    sleep_case(scc_sm_psave, 7'h01, 7'h20, 8'h00, 1'b1);
    sleep_case(scc_sm_standby, 7'h21, 7'h08, 8'h00, 1'b0);
    sleep_case(scc_sm_estandby, 7'h01, 7'h40, 8'h00, 1'b1);
    // reset while asleep restarts with only the default oscillator
    wr(`SCC_OFF_CLKEN, 32'hc8, 2'h0);
    wr(`SCC_OFF_SLEEP, {28'h0, scc_sm_pdown, 1'b1}, 2'h0);
    cpu.do_sleep();
    nvm_busy <= 1'b1;
    repeat (3) @(negedge aclk);
    check("nvm_prog", nvm_clk_en, 1'b1);
    @(posedge aclk);
    nvm_busy <= 1'b0;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check("rst_osc", osc_en, 8'h08);
    check("rst_run", {cpu_run, cpu_halted}, 2'b10);
    complete_run();
  end
endmodule
`default_nettype wire
